/* eeo_fifo.sv */
`timescale 1ns/1ps
module eeo_fifo #(
  parameter int W = 28,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      // Ready is registered from the next count, so it drops on the same edge the buffer fills
      if (push && !pop)
      begin
        count    <= count + 1'b1;
        in_ready <= (count != (AW+1)'(DEPTH - 1));
      end
      else if (pop && !push)
      begin
        count    <= count - 1'b1;
        in_ready <= 1'b1;
      end
    end
  end
endmodule : eeo_fifo

/* eeo_pin_sync.sv */
`timescale 1ns/1ps
module eeo_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1[i]    <= 1'b0;
          s2[i]    <= 1'b0;
          s3[i]    <= 1'b0;
          level[i] <= 1'b0;
        end
        else
        begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // A change is taken only once two stages agree
          if (s2[i] == s3[i])
            level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule : eeo_pin_sync

/* eeo_pkg.sv */
package eeo_pkg;

  // ----------------------------------------------------------
  // Widths
  // ----------------------------------------------------------
  localparam int ANGLE_W = 16;
  localparam int REV_W   = 12;
  localparam int FRAME_W = 28;
  localparam int LINES_W = 20;
  localparam int QUAD_W  = 22;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------
  // Resolution limits, lines before quadrature
  // ----------------------------------------------------------
  localparam logic [LINES_W-1:0] LINES_MIN     = 20'h00100;
  localparam logic [LINES_W-1:0] LINES_MAX_RES = 20'h01000;
  localparam logic [LINES_W-1:0] LINES_MAX_ENC = 20'h80000;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int TOUT_SHORT_NS  = 1300;
  localparam int TOUT_LONG_NS   = 10000;
  localparam int EDGE_MIN_NS    = 250;
  localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int TOUT_LONG_CYC  = (TOUT_LONG_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int EDGE_MIN_CYC   = (EDGE_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int TOUT_W = 11;
  localparam int PACE_W = 6;

  // ----------------------------------------------------------
  // Codes and carriers
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    EEO_FUNC_OFF    = 2'h0,
    EEO_FUNC_INCR   = 2'h1,
    EEO_FUNC_SERIAL = 2'h2,
    EEO_FUNC_INTERP = 2'h3
  } eeo_func_t;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_TAIL  = 3'b100
  } eeo_ser_state_t;

  typedef struct packed {
    logic [REV_W-1:0]   rev;
    logic [ANGLE_W-1:0] angle;
  } eeo_pos_t;

  localparam eeo_pos_t POS_RESET = 28'h0000000;

endpackage : eeo_pkg

/* eeo_reader.sv */
`timescale 1ns/1ps
module eeo_reader
  import eeo_pkg::*;
(
  // Reset
  input  wire logic          rstn,
  // Quadrature and serial data in
  input  wire logic          enc_a,
  input  wire logic          enc_b,
  input  wire logic          ser_data,
  // Serial clock out, decoded count
  output logic               ser_clk,
  output logic [QUAD_W-1:0]  cnt
);
  logic [1:0] ph = 2'h0;
  logic [1:0] step;
  initial ser_clk = 1'b1;
  // A double jump is dropped rather than guessed
  always @(enc_a, enc_b, rstn)
  begin
    step = {enc_a, enc_a ^ enc_b} - ph;
    if (!rstn)
      cnt = '0;
    else if (step == 2'h1)
      cnt = cnt + QUAD_W'(1);
    else if (step == 2'h3)
      cnt = cnt - QUAD_W'(1);
    ph = {enc_a, enc_a ^ enc_b};
  end
  // Clock stands high between frames; bits taken late in the low phase
  task automatic read_frame(output logic [FRAME_W-1:0] f,
                            output logic tail);
    f = '0;
    ser_clk = 1'b0;
    #24;
    for (int i = 0; i < FRAME_W; i++)
    begin
      ser_clk = 1'b1;
      #24;
      ser_clk = 1'b0;
      #24;
      f = {f[FRAME_W-2:0], ser_data};
    end
    ser_clk = 1'b1;
    #48;
    tail = ser_data;
  endtask : read_frame
endmodule : eeo_reader

/* eeo_top.sv */
`timescale 1ns/1ps
// What this block does
// - Builds shaft position and turn count from cyclic absolute feedback.
// - Selector: code 1 synthesized quadrature, code 3 passes sine lines.
// - Incremental mode drives A and B in quadrature plus a zero pulse.
// - Lines per turn clamp to 256..4096 resolver, 256..524288 encoder.
// - One zero pulse per turn, only while A and B are both high.
// - Zero pulse angle is shifted by the stored offset setting.
// - Clockwise rotation counts up on both incremental and serial outputs.
// - Serial frame carries exactly 28 data bits.
// - Turn count 12 bits MSB first, then fixed 16-bit angle MSB first.
// - Serial word sent as Gray or binary; binary is the default.
// - Serial idle timeout selectable between 1.3 us and 10 us.
module eeo_top
  import eeo_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Feedback angle samples
  input  wire logic [ANGLE_W-1:0]    fb_angle,
  input  wire logic                  fb_valid,
  output logic                       fb_ready,
  // Settings
  input  wire eeo_pkg::eeo_func_t    emulation_function_select,
  input  wire logic                  fb_is_encoder,
  input  wire logic [LINES_W-1:0]    resolution_lines,
  input  wire logic [ANGLE_W-1:0]    zero_pulse_offset,
  input  wire logic                  serial_code_format,
  input  wire logic                  serial_timeout_setting,
  // Sine line pass-through pins
  input  wire logic                  sine_line_a_in,
  input  wire logic                  sine_line_b_in,
  input  wire logic                  sine_line_zero_in,
  // Incremental outputs
  output logic                       enc_a,
  output logic                       enc_b,
  output logic                       enc_zero,
  // Serial link
  input  wire logic                  ser_clk_in,
  output logic                       ser_data,
  // Status
  output logic                       ser_frame_active
);
  import eeo_pkg::*;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [FRAME_W-1:0] to_gray(
    input logic [FRAME_W-1:0] b
  );
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // ----------------------------------------------------------
  // Position tracking
  // ----------------------------------------------------------
  logic [ANGLE_W-1:0] prev_angle;
  logic [REV_W-1:0]   rev_count;
  logic [REV_W-1:0]   next_rev;
  logic               fb_take;
  eeo_pos_t           fifo_in;
  eeo_pos_t           fifo_out;
  logic               fifo_valid;
  logic               fifo_pop_ready;
  logic               fifo_in_ready;

  assign fb_take = fb_valid && fifo_in_ready;

  // Angle wrap across the top quadrant means a turn completed
  always_comb
  begin
    next_rev = rev_count;
    if (prev_angle[15:14] == 2'b11 && fb_angle[15:14] == 2'b00)
      next_rev = rev_count + 1'b1;
    else if (prev_angle[15:14] == 2'b00 && fb_angle[15:14] == 2'b11)
      next_rev = rev_count - 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_angle <= '0;
      rev_count  <= '0;
    end
    else if (fb_take)
    begin
      prev_angle <= fb_angle;
      rev_count  <= next_rev;
    end
  end

  assign fifo_in = '{rev: next_rev, angle: fb_angle};

  eeo_fifo #(
    .W     (FRAME_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_data   (fifo_in),
    .in_valid  (fb_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop_ready)
  );

  assign fb_ready = fifo_in_ready;

  // Latest position taken from the buffer
  eeo_pos_t pos;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pos <= POS_RESET;
    else if (fifo_valid && fifo_pop_ready)
      pos <= fifo_out;
  end

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [2:0] sine_lvl;
  logic       ser_clk_lvl;

  eeo_pin_sync #(.W(3)) u_sync_sine (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   ({sine_line_zero_in, sine_line_b_in, sine_line_a_in}),
    .level (sine_lvl)
  );

  eeo_pin_sync #(.W(1)) u_sync_sclk (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (ser_clk_in),
    .level (ser_clk_lvl)
  );

  // ----------------------------------------------------------
  // Incremental emulation
  // ----------------------------------------------------------
  logic [LINES_W-1:0]   lines_eff;
  logic [QUAD_W-1:0]    quad;
  logic [ANGLE_W-1:0]   shifted;
  logic [QUAD_W+15:0]   product;
  logic [QUAD_W-1:0]    target;
  logic [QUAD_W-1:0]    edge_cnt;
  logic [QUAD_W:0]      diff_wide;
  logic [QUAD_W-1:0]    diff;
  logic                 step_up;
  logic [PACE_W-1:0]    pace;
  logic                 incr_mode;

  assign incr_mode = (emulation_function_select == EEO_FUNC_INCR);

  always_comb
  begin
    lines_eff = resolution_lines;
    if (resolution_lines < LINES_MIN)
      lines_eff = LINES_MIN;
    else if (!fb_is_encoder && resolution_lines > LINES_MAX_RES)
      lines_eff = LINES_MAX_RES;
    else if (resolution_lines > LINES_MAX_ENC)
      lines_eff = LINES_MAX_ENC;
  end

  assign quad    = {lines_eff, 2'b00};
  // Offset moves count zero, hence the zero pulse, around the turn
  assign shifted = pos.angle - zero_pulse_offset;
  assign product = shifted * quad;
  assign target  = product[QUAD_W+15:16];

  // Modular distance from emitted count to target
  always_comb
  begin
    if (target >= edge_cnt)
      diff_wide = {1'b0, target - edge_cnt};
    else
      diff_wide = {1'b0, target} + {1'b0, quad} - {1'b0, edge_cnt};
    diff    = diff_wide[QUAD_W-1:0];
    step_up = (diff < (quad >> 1));
  end

  // Stall the buffer while edges are still owed, so it really fills
  assign fifo_pop_ready = incr_mode ? (diff == '0) : 1'b1;

  // Edges are paced to keep line rate under the 1 MHz limit
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      edge_cnt <= '0;
      pace     <= '0;
    end
    else if (edge_cnt >= quad)
    begin
      edge_cnt <= '0;
      pace     <= '0;
    end
    else if (pace != '0)
      pace <= pace - 1'b1;
    else if (incr_mode && diff != '0)
    begin
      pace <= PACE_W'(EDGE_MIN_CYC - 1);
      if (step_up)
        edge_cnt <= (edge_cnt == quad - 1'b1) ? '0
                    : edge_cnt + 1'b1;
      else
        edge_cnt <= (edge_cnt == '0) ? quad - 1'b1
                    : edge_cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      enc_a    <= 1'b0;
      enc_b    <= 1'b0;
      enc_zero <= 1'b0;
    end
    else
    begin
      case (emulation_function_select)
        EEO_FUNC_INCR:
        begin
          // B leads A by a quarter line when counting up
          enc_a    <= edge_cnt[1];
          enc_b    <= edge_cnt[1] ^ edge_cnt[0];
          enc_zero <= (edge_cnt[QUAD_W-1:2] == '0)
                      && (edge_cnt[1:0] == 2'b10);
        end
        EEO_FUNC_INTERP:
        begin
          enc_a    <= sine_lvl[0];
          enc_b    <= sine_lvl[1];
          enc_zero <= sine_lvl[2];
        end
        default:
        begin
          enc_a    <= 1'b0;
          enc_b    <= 1'b0;
          enc_zero <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Serial absolute emulation
  // ----------------------------------------------------------
  eeo_ser_state_t     ser_state;
  logic               clk_prev;
  logic               clk_fall;
  logic               clk_rise;
  logic [FRAME_W-1:0] shreg;
  logic [4:0]         bit_cnt;
  logic [TOUT_W-1:0]  idle_cnt;
  logic [TOUT_W-1:0]  tout_lim;
  logic [FRAME_W-1:0] frame_word;
  logic               ser_mode;

  assign ser_mode = (emulation_function_select == EEO_FUNC_SERIAL);
  assign clk_fall = clk_prev && !ser_clk_lvl;
  assign clk_rise = !clk_prev && ser_clk_lvl;
  assign tout_lim = serial_timeout_setting
                    ? TOUT_W'(TOUT_LONG_CYC)
                    : TOUT_W'(TOUT_SHORT_CYC);
  // Turns first, then angle, both MSB first
  assign frame_word = serial_code_format ? to_gray(pos)
                      : pos;

  always_ff @(posedge mclk or negedge rstn)
  begin
    // Matches the filter's reset level, so no false fall follows reset
    if (!rstn)
      clk_prev <= 1'b0;
    else
      clk_prev <= ser_clk_lvl;
  end

  // Any clock edge restarts the idle timer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      idle_cnt <= '0;
    else if (clk_fall || clk_rise || ser_state == SER_IDLE)
      idle_cnt <= '0;
    else if (idle_cnt != tout_lim)
      idle_cnt <= idle_cnt + 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ser_state <= SER_IDLE;
      shreg     <= '0;
      bit_cnt   <= '0;
      ser_data  <= 1'b1;
    end
    else if (!ser_mode)
    begin
      ser_state <= SER_IDLE;
      ser_data  <= 1'b1;
    end
    else
    begin
      case (ser_state)
        SER_IDLE:
        begin
          ser_data <= 1'b1;
          if (clk_fall)
          begin
            shreg     <= frame_word;
            bit_cnt   <= '0;
            ser_state <= SER_SHIFT;
          end
        end
        SER_SHIFT:
        begin
          if (idle_cnt == tout_lim)
          begin
            // Reader gave up mid-frame
            ser_state <= SER_IDLE;
            ser_data  <= 1'b1;
          end
          else if (clk_rise)
          begin
            if (bit_cnt == 5'(FRAME_W))
            begin
              ser_data  <= 1'b0;
              ser_state <= SER_TAIL;
            end
            else
            begin
              ser_data <= shreg[FRAME_W-1];
              shreg    <= {shreg[FRAME_W-2:0], 1'b0};
              bit_cnt  <= bit_cnt + 1'b1;
            end
          end
        end
        SER_TAIL:
        begin
          // Data held low until the reader stops clocking
          ser_data <= 1'b0;
          if (idle_cnt == tout_lim)
          begin
            ser_state <= SER_IDLE;
            ser_data  <= 1'b1;
          end
        end
        default:
        begin
          ser_state <= SER_IDLE;
          ser_data  <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ser_frame_active <= 1'b0;
    else
      ser_frame_active <= ser_mode && (ser_state != SER_IDLE);
  end

endmodule : eeo_top

/* eeo_top_chk.sv */
`timescale 1ns/1ps
module eeo_top_chk
  import eeo_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Settings and pins
  input  wire eeo_pkg::eeo_func_t emulation_function_select,
  input  wire logic               serial_timeout_setting,
  input  wire logic               sine_line_a_in,
  input  wire logic               ser_clk_in,
  // Outputs
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  input  wire logic               enc_zero,
  input  wire logic               ser_data,
  input  wire logic               ser_frame_active
);
  // ----------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------
  logic       incr;
  logic [1:0] ab_q;
  logic       sc_q;
  int         gap;
  int         quiet;
  int         lim;
  assign incr = emulation_function_select == EEO_FUNC_INCR;
  assign lim  = serial_timeout_setting ? TOUT_LONG_CYC : TOUT_SHORT_CYC;
  // Counted from the raw pin, so the filter delay adds margin to a_tout_min but uses some of the 12-cycle slack of a_tout_max
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ab_q  <= 2'h0;
      sc_q  <= 1'b1;
      gap   <= 63;
      quiet <= 0;
    end
    else
    begin
      ab_q  <= {enc_a, enc_b};
      sc_q  <= ser_clk_in;
      gap   <= ({enc_a, enc_b} != ab_q) ? 0 : (gap < 63 ? gap + 1 : 63);
      quiet <= (ser_clk_in != sc_q) ? 0 : (quiet < 4095 ? quiet + 1 : 4095);
    end
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_quad_quiet;
    (!incr && emulation_function_select != EEO_FUNC_INTERP) [*3];
  endsequence
  sequence s_frame_start;
    $fell(ser_clk_in) && !ser_frame_active
      && emulation_function_select == EEO_FUNC_SERIAL;
  endsequence
  a_zero_in_ab: assert property (incr && $past(incr) && enc_zero
    |-> enc_a && enc_b) else $error("zero pulse outside A and B high");
  a_quad_one_edge: assert property (incr && $past(incr)
    |-> !($changed(enc_a) && $changed(enc_b))) else $error("A and B moved");
  a_step_pace: assert property (incr && $past(incr)
    && $changed({enc_a, enc_b}) |-> gap >= 49) else $error("step too soon");
  a_quad_off: assert property (s_quad_quiet
    |-> !enc_a && !enc_b && !enc_zero) else $error("quadrature not quiet");
  a_pass_rise: assert property ($rose(sine_line_a_in)
    && emulation_function_select == EEO_FUNC_INTERP |-> ##[1:8] enc_a)
    else $error("sine line not passed");
  a_frame_start: assert property (s_frame_start
    |-> ##[2:8] ser_frame_active) else $error("frame did not start");
  a_idle_high: assert property (!ser_frame_active [*2]
    |-> ser_data) else $error("serial line not idle high");
  a_tout_min: assert property ($fell(ser_frame_active)
    |-> quiet >= lim) else $error("frame ended early");
  a_tout_max: assert property (ser_frame_active
    |-> quiet <= lim + 12) else $error("frame ended late");
endmodule : eeo_top_chk

bind eeo_top eeo_top_chk u_chk (.mclk, .rstn, .emulation_function_select,
  .serial_timeout_setting, .sine_line_a_in, .ser_clk_in, .enc_a, .enc_b,
  .enc_zero, .ser_data, .ser_frame_active);

/* encoder_emulation_output_tb.sv */
`timescale 1ns/1ps
module encoder_emulation_output_tb;
  import eeo_pkg::*;
  typedef struct {
    logic [ANGLE_W-1:0] off;
    logic [ANGLE_W-1:0] ang;
    logic [2:0]         abz;
    logic [9:0]         cnt;
  } eeo_row_t;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic [ANGLE_W-1:0] fb_angle = '0;
  logic               fb_valid = 1'b0;
  logic               fb_ready;
  eeo_func_t          mode = EEO_FUNC_OFF;
  logic               fb_is_encoder = 1'b0;
  logic [ANGLE_W-1:0] offset = '0;
  logic [LINES_W-1:0] lines = 20'h00080;
  logic               code_fmt = 1'b0;
  logic               tout_sel = 1'b0;
  logic [2:0]         sine = 3'h0;
  logic               enc_a;
  logic               enc_b;
  logic               enc_zero;
  logic               ser_clk_in;
  logic               ser_data;
  logic               ser_frame_active;
  logic [QUAD_W-1:0]  cnt;
  logic [FRAME_W-1:0] frame;
  logic [FRAME_W-1:0] want;
  logic               tail;
  int                 n_fail = 0;
  int                 check_count = 0;
  // Lines start at 128: clamps up to 256, so 1024 counts a turn
  eeo_row_t rows [6] = '{
    '{16'h0000, 16'h0040, 3'h2, 10'h001},
    '{16'h0000, 16'h0080, 3'h7, 10'h002},
    '{16'h0000, 16'h00C0, 3'h4, 10'h003},
    '{16'h0000, 16'h0180, 3'h6, 10'h006},
    '{16'h0080, 16'h0100, 3'h7, 10'h002},
    '{16'h0080, 16'h0040, 3'h4, 10'h3FF}};
  always #2.5 mclk = ~mclk;
  eeo_top dut (.mclk, .rstn, .fb_angle, .fb_valid, .fb_ready,
    .emulation_function_select(mode), .fb_is_encoder,
    .resolution_lines(lines), .zero_pulse_offset(offset),
    .serial_code_format(code_fmt), .serial_timeout_setting(tout_sel),
    .sine_line_a_in(sine[2]), .sine_line_b_in(sine[1]),
    .sine_line_zero_in(sine[0]), .enc_a, .enc_b, .enc_zero, .ser_clk_in,
    .ser_data, .ser_frame_active);
  eeo_reader rdr (.rstn, .enc_a, .enc_b, .ser_data, .ser_clk(ser_clk_in),
    .cnt);
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input string what, input logic [FRAME_W-1:0] seen,
                       input logic [FRAME_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask : check
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic push(input logic [ANGLE_W-1:0] ang);
    int k;
    fb_angle = ang;
    fb_valid = 1'b1;
    k = 0;
    while (fb_ready !== 1'b1 && k < 50)
    begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    fb_valid = 1'b0;
    // Let an edge pass so a following push never re-raises valid at once
    @(negedge mclk);
    check("taken", 28'(k < 50), 28'h1);
    if (k >= 50)
      report_and_stop();
  endtask : push
  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial
  begin
    int k;
    repeat (5) @(negedge mclk);
    check("reset", 28'({fb_ready, enc_a, enc_b, enc_zero, ser_data,
          ser_frame_active}), 28'h22);
    @(negedge mclk);
    rstn = 1'b1;
    mode = EEO_FUNC_INCR;
    foreach (rows[i])
    begin
      offset = rows[i].off;
      push(rows[i].ang);
      repeat (300) @(negedge mclk);
      check("quad", 28'({enc_a, enc_b, enc_zero}), 28'(rows[i].abz));
      check("count", 28'(cnt[9:0]), 28'(rows[i].cnt));
    end
    // Buffer stalls while nine steps are pending, then empties
    fb_is_encoder = 1'b1;
    offset = '0;
    fb_angle = 16'h0200;
    fb_valid = 1'b1;
    repeat (12) @(negedge mclk);
    check("full", 28'(fb_ready), 28'h0);
    fb_valid = 1'b0;
    k = 0;
    while (fb_ready !== 1'b1 && k < 2000)
    begin
      @(negedge mclk);
      k++;
    end
    check("drain wait", 28'(k < 2000), 28'h1);
    if (k >= 2000)
      report_and_stop();
    // Seven more steps of 50 cycles are owed after the first word drains
    repeat (400) @(negedge mclk);
    check("drained", 28'(fb_ready), 28'h1);
    check("count", 28'(cnt[9:0]), 28'h008);
    mode = EEO_FUNC_INTERP;
    for (int i = 0; i < 2; i++)
    begin
      sine = i ? 3'h2 : 3'h5;
      repeat (12) @(negedge mclk);
      check("pass", 28'({enc_a, enc_b, enc_zero}), 28'(sine));
    end
    // Angle crosses from the top quarter into the bottom: one turn up
    mode = EEO_FUNC_SERIAL;
    sine = 3'h0;
    push(16'h8000);
    push(16'hC000);
    push(16'h1234);
    repeat (20) @(negedge mclk);
    for (int m = 0; m < 2; m++)
    begin
      code_fmt = m[0];
      tout_sel = m[0];
      want = 28'h0011234;
      if (m)
        want = want ^ (want >> 1);
      repeat (10) @(negedge mclk);
      rdr.read_frame(frame, tail);
      check("frame", frame, want);
      check("tail", 28'(tail), 28'h0);
      repeat (m ? 1900 : 200) @(negedge mclk);
      check("hold", 28'({ser_data, ser_frame_active}), 28'h1);
      repeat (m ? 200 : 80) @(negedge mclk);
      check("idle", 28'({ser_data, ser_frame_active}), 28'h2);
    end
    // Above the resolver limit lines clamp to 4096; the encoder's do not
    push(16'h0004);
    repeat (4) @(negedge mclk);
    want = 28'(cnt);
    lines = 20'h02000;
    fb_is_encoder = 1'b0;
    mode = EEO_FUNC_INCR;
    repeat (400) @(negedge mclk);
    check("clamp", 28'({enc_a, enc_b, enc_zero}), 28'h2);
    check("back", 28'({cnt[9:0] - want[9:0]}), 28'h3F9);
    fb_is_encoder = 1'b1;
    repeat (60) @(negedge mclk);
    check("wide", 28'({enc_a, enc_b, enc_zero}), 28'h7);
    // Reset again in mid-run
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    check("reset again", 28'({fb_ready, enc_a, enc_b, enc_zero, ser_data,
          ser_frame_active}), 28'h22);
    rstn = 1'b1;
    repeat (10) @(negedge mclk);
    check("after reset", 28'({enc_a, enc_b, enc_zero}), 28'h0);
    report_and_stop();
  end
endmodule : encoder_emulation_output_tb
